// >>> pkg/mic_pkg.sv
package mic_pkg;
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int VEC_W = 12;
    localparam int NUM_W = 3;
    localparam int NSRC = 5;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PEND = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_OPT = 8'hC8;

    // interrupt_option fields and reset value
    localparam logic [7:0] OPT_RESET = 8'h00;
    localparam int OPT_LES_BIT = 6;
    localparam int OPT_ESB_BIT = 5;
    localparam int OPT_GEN_BIT = 4;

    // status and mask reset values, pending word layout
    localparam logic [NSRC-1:0] STAT_RESET = 5'h00;
    localparam logic [NSRC-1:0] MASK_RESET = 5'h00;
    localparam int PEND_LP_LSB = 8;

    // vector locations in program space (first byte of each pair)
    localparam logic [VEC_W-1:0] VEC_ADDR_NMI = 12'hFFC;
    localparam logic [VEC_W-1:0] VEC_ADDR_1 = 12'hFF6;
    localparam logic [VEC_W-1:0] VEC_ADDR_2 = 12'hFF4;
    localparam logic [VEC_W-1:0] VEC_ADDR_3 = 12'hFF2;
    localparam logic [VEC_W-1:0] VEC_ADDR_4 = 12'hFF0;
    localparam logic [NUM_W-1:0] NUM_NMI = 3'h0;
    localparam logic [NUM_W-1:0] NUM_1 = 3'h1;
    localparam logic [NUM_W-1:0] NUM_2 = 3'h2;
    localparam logic [NUM_W-1:0] NUM_3 = 3'h3;
    localparam logic [NUM_W-1:0] NUM_4 = 3'h4;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // low power state; bit 1 = asleep, bit 0 = stop
    typedef enum logic [1:0] {
        LP_RUN = 2'b00,
        LP_WAIT = 2'b10,
        LP_STOP = 2'b11
    } mic_lp_t;
endpackage

// >>> pkg/mic_regbus_if.sv
`timescale 1ns/1ps
interface mic_regbus_if;
    logic wr_en;
    logic [mic_pkg::ADDR_W-1:0] wr_addr;
    logic [mic_pkg::DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic rd_en;
    logic [mic_pkg::ADDR_W-1:0] rd_addr;
    logic [mic_pkg::DATA_W-1:0] rd_data;
    logic rd_err;
    modport bridge (
        output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
        input wr_err, rd_data, rd_err
    );
    modport regs (
        input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
        output wr_err, rd_data, rd_err
    );
endinterface

// >>> src/mic_axil.sv
`timescale 1ns/1ps
module mic_axil (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic awvalid,
    output logic awready,
    input wire logic [mic_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [mic_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [mic_pkg::ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [mic_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    mic_regbus_if.bridge rb
);
    import mic_pkg::*;

    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;

    // address and data are held separately so either may come first
    wire aw_take = awvalid && awready_q;
    wire w_take = wvalid && wready_q;
    wire do_wr = !awready_q && !wready_q && !bvalid_q;
    wire do_rd = arvalid && arready_q;

    assign rb.wr_en = ce && do_wr;
    assign rb.wr_addr = awaddr_q;
    assign rb.wr_data = wdata_q;
    assign rb.wr_strb = wstrb_q;
    assign rb.rd_en = ce && do_rd;
    assign rb.rd_addr = araddr;

    // write channels
    always_ff @(posedge clk) begin
        if (srst) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (ce) begin
            if (aw_take) begin
                awready_q <= 1'b0;
                awaddr_q <= awaddr;
            end
            if (w_take) begin
                wready_q <= 1'b0;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (do_wr) begin
                awready_q <= 1'b1;
                wready_q <= 1'b1;
                bvalid_q <= 1'b1;
                bresp_q <= rb.wr_err ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // read channels; data is captured so it stays put under back-pressure
    always_ff @(posedge clk) begin
        if (srst) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (ce) begin
            if (do_rd) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rb.rd_data;
                rresp_q <= rb.rd_err ? RESP_SLVERR : RESP_OKAY;
            end else if (rvalid_q && rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // a response must wait for its ready without changing
    resp_hold_a: assert property (
        @(posedge clk) disable iff (srst)
        rvalid_q && !rready |=> rvalid_q && $stable(rdata_q))
        else $error("read response dropped before rready");
endmodule // mic_axil

// >>> src/mic_extline.sv
`timescale 1ns/1ps
module mic_extline #(
    parameter int NPIN = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [NPIN-1:0] pins,
    input wire logic [NPIN-1:0] en,
    input wire logic pol,
    output logic line_low,
    output logic edge_evt
);
    if (NPIN < 1 || NPIN > 8) begin : g_bad_npin
        $error("mic_extline: NPIN must be 1 to 8");
    end

    logic comb_q;
    logic [NPIN-1:0] en_q;
    logic [NPIN-1:0] term;

    // pins not in interrupt mode sit at the pulled-up idle level;
    // the shared and-gate lets one stuck pin hide every other one
    for (genvar i = 0; i < NPIN; i++) begin : g_term
        assign term[i] = en[i] ? (pins[i] ^ pol) : 1'b1;
    end

    wire comb = &term;
    // leaving interrupt mode on a low pin in rising mode fakes an edge
    wire spur = pol && |(en_q & ~en & ~pins);

    // a fall of the combined line is the active edge; a flip to rising
    // polarity on an idle high pin also falls, which is the known spurious edge
    assign edge_evt = (comb_q && !comb) || spur;
    assign line_low = !comb;

    always_ff @(posedge clk) begin
        if (srst) begin
            comb_q <= 1'b1;
            en_q <= '0;
        end else if (ce) begin
            comb_q <= comb;
            en_q <= en;
        end
    end
endmodule // mic_extline

// >>> src/mic_top.sv
`timescale 1ns/1ps
// Summary of operation
// - four maskable sources and one non-maskable, each with a fixed vector.
// - maskable requests are latched while disabled and served once enabled.
// - taking a request loads the program counter with its vector address.
// - events can share a vector; each event flag is readable by software.
// - external pins wake from stop and are vectored, both only with the global enable.
// - port A uses vector 1 at FF6h, port B vector 2 at FF4h.
// - option bit 6 picks falling edge or low level for vector 1.
// - vector 2 is edge only; option bit 5 picks falling or rising.
// - option bit 4 is the global enable for all maskable sources.
// - edge latch sets on active edge, clears at service; one kept.
// - level mode stores nothing; the pin is sampled after an instruction.
// - turning vector 2 to rising with an idle pulled-up pin fakes a request.
// - one vector 2 pin stuck at its after-edge level blocks the others.
// - mode changes of a low vector 2 pin can latch a spurious request.
// - option register is write-only, resets to zero, reads give nothing.
// - without global enable the nmi is served but never wakes.
// - wait or stop is refused while an enabled request is pending.
module mic_top #(
    parameter int NPIN_A = 4,
    parameter int NPIN_B = 4,
    parameter bit HAS_CONV = 1'b1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [mic_pkg::ADDR_W-1:0] s_axil_awaddr,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    input wire logic [mic_pkg::DATA_W-1:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    output logic [1:0] s_axil_bresp,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    input wire logic [mic_pkg::ADDR_W-1:0] s_axil_araddr,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    output logic [mic_pkg::DATA_W-1:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic irq,
    input wire logic nmi_pin_n,
    input wire logic [NPIN_A-1:0] porta_pins,
    input wire logic [NPIN_A-1:0] porta_irq_en,
    input wire logic [NPIN_B-1:0] portb_pins,
    input wire logic [NPIN_B-1:0] portb_irq_en,
    input wire logic timer_zero_evt,
    input wire logic conv_eoc_evt,
    input wire logic core_instr_done,
    input wire logic core_in_isr,
    input wire logic core_in_nmi,
    input wire logic core_lp_req,
    input wire logic core_lp_stop,
    output logic pc_load,
    output logic [mic_pkg::VEC_W-1:0] pc_vector,
    output logic [mic_pkg::NUM_W-1:0] irq_vec_num,
    output logic lowpower,
    output logic lp_stop,
    output logic lp_refused,
    output logic wake
);
    import mic_pkg::*;

    localparam int SYNC_W = 1 + NPIN_A + NPIN_B;

    mic_regbus_if rb ();

    mic_axil u_axil (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .awvalid(s_axil_awvalid),
        .awready(s_axil_awready),
        .awaddr(s_axil_awaddr),
        .wvalid(s_axil_wvalid),
        .wready(s_axil_wready),
        .wdata(s_axil_wdata),
        .wstrb(s_axil_wstrb),
        .bvalid(s_axil_bvalid),
        .bready(s_axil_bready),
        .bresp(s_axil_bresp),
        .arvalid(s_axil_arvalid),
        .arready(s_axil_arready),
        .araddr(s_axil_araddr),
        .rvalid(s_axil_rvalid),
        .rready(s_axil_rready),
        .rdata(s_axil_rdata),
        .rresp(s_axil_rresp),
        .rb(rb)
    );

    // pin synchroniser; idle level is the pulled-up high
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_q <= '1;
            sync2_q <= '1;
        end else if (ce) begin
            sync1_q <= {portb_pins, porta_pins, nmi_pin_n};
            sync2_q <= sync1_q;
        end
    end

    wire nmi_s = sync2_q[0];
    wire [NPIN_A-1:0] pa_s = sync2_q[NPIN_A:1];
    wire [NPIN_B-1:0] pb_s = sync2_q[SYNC_W-1:NPIN_A+1];

    // interrupt_option: only bits 6..4 are kept, the rest is dropped
    logic les_q, esb_q, gen_q;
    wire wr_opt = rb.wr_en && rb.wr_addr == OFF_OPT && rb.wr_strb[0];
    always_ff @(posedge clk) begin
        if (srst) begin
            les_q <= OPT_RESET[OPT_LES_BIT];
            esb_q <= OPT_RESET[OPT_ESB_BIT];
            gen_q <= OPT_RESET[OPT_GEN_BIT];
        end else if (ce && wr_opt) begin
            les_q <= rb.wr_data[OPT_LES_BIT];
            esb_q <= rb.wr_data[OPT_ESB_BIT];
            gen_q <= rb.wr_data[OPT_GEN_BIT];
        end
    end

    // port A line: always falling sense, level use decided here
    logic a_low, a_edge, b_edge;
    mic_extline #(.NPIN(NPIN_A)) u_vec1 (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .pins(pa_s),
        .en(porta_irq_en),
        .pol(1'b0),
        .line_low(a_low),
        .edge_evt(a_edge)
    );

    // port B line: edge only, polarity from the option register
    mic_extline #(.NPIN(NPIN_B)) u_vec2 (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .pins(pb_s),
        .en(portb_irq_en),
        .pol(esb_q),
        .line_low(),
        .edge_evt(b_edge)
    );

    // event sources; the converter is absent on smaller parts
    logic nmi_prev_q;
    wire nmi_fall = nmi_prev_q && !nmi_s;
    wire conv_evt = HAS_CONV && conv_eoc_evt;

    // pending latches and eligibility
    logic nmi_p_q, v1_p_q, v2_p_q, v3_p_q, v4_p_q;
    wire v1_req = les_q ? a_low : v1_p_q;
    wire nmi_ok = nmi_p_q && !core_in_nmi;
    wire mask_ok = gen_q && !core_in_isr && !core_in_nmi;
    wire r1 = mask_ok && v1_req;
    wire r2 = mask_ok && v2_p_q;
    wire r3 = mask_ok && v3_p_q;
    wire r4 = mask_ok && v4_p_q;

    // fixed priority, nmi highest and converter lowest
    wire take_nmi = core_instr_done && nmi_ok;
    wire take1 = core_instr_done && !nmi_ok && r1;
    wire take2 = core_instr_done && !nmi_ok && !r1 && r2;
    wire take3 = core_instr_done && !nmi_ok && !r1 && !r2 && r3;
    wire take4 = core_instr_done && !nmi_ok && !r1 && !r2 && !r3 && r4;
    wire take_any = take_nmi || take1 || take2 || take3 || take4;

    // vector table lookup for the winner
    wire [VEC_W-1:0] sel_addr = take_nmi ? VEC_ADDR_NMI :
        take1 ? VEC_ADDR_1 : take2 ? VEC_ADDR_2 :
        take3 ? VEC_ADDR_3 : VEC_ADDR_4;
    wire [NUM_W-1:0] sel_num = take_nmi ? NUM_NMI :
        take1 ? NUM_1 : take2 ? NUM_2 : take3 ? NUM_3 : NUM_4;

    // a new edge in the service cycle wins over the clear; a second
    // edge before service just finds the latch already set
    wire nmi_p_d = nmi_fall || (nmi_p_q && !take_nmi);
    wire v1_p_d = !les_q && (a_edge || (v1_p_q && !take1));
    wire v2_p_d = b_edge || (v2_p_q && !take2);
    wire v3_p_d = timer_zero_evt || (v3_p_q && !take3);
    wire v4_p_d = conv_evt || (v4_p_q && !take4);

    always_ff @(posedge clk) begin
        if (srst) begin
            nmi_prev_q <= 1'b1;
            nmi_p_q <= 1'b0;
            v1_p_q <= 1'b0;
            v2_p_q <= 1'b0;
            v3_p_q <= 1'b0;
            v4_p_q <= 1'b0;
        end else if (ce) begin
            nmi_prev_q <= nmi_s;
            nmi_p_q <= nmi_p_d;
            v1_p_q <= v1_p_d;
            v2_p_q <= v2_p_d;
            v3_p_q <= v3_p_d;
            v4_p_q <= v4_p_d;
        end
    end

    // program counter load toward the core
    logic pc_load_q;
    logic [VEC_W-1:0] pc_vector_q;
    logic [NUM_W-1:0] irq_vec_num_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            pc_load_q <= 1'b0;
            pc_vector_q <= '0;
            irq_vec_num_q <= '0;
        end else if (ce) begin
            pc_load_q <= take_any;
            if (take_any) begin
                pc_vector_q <= sel_addr;
                irq_vec_num_q <= sel_num;
            end
        end
    end

    // sticky event flags, write one to clear, set wins over clear
    logic [NSRC-1:0] stat_q, mask_q;
    logic irq_q;
    wire v1_evt = les_q ? a_low : a_edge;
    wire [NSRC-1:0] ev = {conv_evt, timer_zero_evt, b_edge, v1_evt, nmi_fall};
    wire wr_stat = rb.wr_en && rb.wr_addr == OFF_STATUS && rb.wr_strb[0];
    wire wr_mask = rb.wr_en && rb.wr_addr == OFF_MASK && rb.wr_strb[0];
    wire [NSRC-1:0] w1c = wr_stat ? rb.wr_data[NSRC-1:0] : '0;
    wire [NSRC-1:0] stat_d = ev | (stat_q & ~w1c);
    always_ff @(posedge clk) begin
        if (srst) begin
            stat_q <= STAT_RESET;
            mask_q <= MASK_RESET;
            irq_q <= 1'b0;
        end else if (ce) begin
            stat_q <= stat_d;
            if (wr_mask) begin
                mask_q <= rb.wr_data[NSRC-1:0];
            end
            irq_q <= |(stat_q & mask_q);
        end
    end

    // low power: requests that may wake, and those that refuse entry
    mic_lp_t lp_q, lp_d;
    logic refuse_d, wake_d, lp_refused_q, wake_q;
    wire pend_en = nmi_p_q ||
        (gen_q && (v1_req || v2_p_q || v3_p_q || v4_p_q));
    wire wake_stop = gen_q &&
        (nmi_p_q || v1_req || v2_p_q || v3_p_q);
    wire wake_wait = wake_stop || (gen_q && v4_p_q);

    always_comb begin
        lp_d = lp_q;
        refuse_d = 1'b0;
        wake_d = 1'b0;
        unique case (lp_q)
            LP_RUN: begin
                if (core_lp_req && pend_en) begin
                    refuse_d = 1'b1;
                end else if (core_lp_req) begin
                    lp_d = core_lp_stop ? LP_STOP : LP_WAIT;
                end
            end
            LP_WAIT: begin
                if (wake_wait) begin
                    lp_d = LP_RUN;
                    wake_d = 1'b1;
                end
            end
            LP_STOP: begin
                if (wake_stop) begin
                    lp_d = LP_RUN;
                    wake_d = 1'b1;
                end
            end
            default: begin
                lp_d = LP_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            lp_q <= LP_RUN;
            lp_refused_q <= 1'b0;
            wake_q <= 1'b0;
        end else if (ce) begin
            lp_q <= lp_d;
            lp_refused_q <= refuse_d;
            wake_q <= wake_d;
        end
    end

    // register reads; the option register is write-only and reads zero
    wire [DATA_W-1:0] pend_word = {22'h000000, lp_q, 3'h0,
        v4_p_q, v3_p_q, v2_p_q, v1_req, nmi_p_q};
    wire rd_known = rb.rd_addr == OFF_STATUS || rb.rd_addr == OFF_MASK ||
        rb.rd_addr == OFF_PEND || rb.rd_addr == OFF_OPT;
    wire wr_known = rb.wr_addr == OFF_STATUS || rb.wr_addr == OFF_MASK ||
        rb.wr_addr == OFF_OPT;
    assign rb.rd_data = (rb.rd_addr == OFF_STATUS) ?
        {{(DATA_W-NSRC){1'b0}}, stat_q} :
        (rb.rd_addr == OFF_MASK) ? {{(DATA_W-NSRC){1'b0}}, mask_q} :
        (rb.rd_addr == OFF_PEND) ? pend_word : 32'h00000000;
    assign rb.rd_err = !rd_known;
    assign rb.wr_err = !wr_known;

    assign irq = irq_q;
    assign pc_load = pc_load_q;
    assign pc_vector = pc_vector_q;
    assign irq_vec_num = irq_vec_num_q;
    assign lowpower = lp_q[1];
    assign lp_stop = lp_q[0];
    assign lp_refused = lp_refused_q;
    assign wake = wake_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // nmi beats a vector 1 request in the same sample
    nmi_first_a: assert property (
        ce && take_nmi && r1 |=> pc_load_q && irq_vec_num_q == NUM_NMI)
        else $error("nmi not preferred over vector 1");

    // vector 1 service loads its own location
    vec1_addr_a: assert property (
        ce && take1 |=> pc_load_q && pc_vector_q == VEC_ADDR_1)
        else $error("vector 1 address wrong");

    // no maskable service while globally disabled
    gen_block_a: assert property (
        ce && core_instr_done && !gen_q && !nmi_ok |=> !pc_load_q)
        else $error("maskable taken with global enable clear");

    // a latched request survives while disabled
    held_pend_a: assert property (
        ce && !gen_q && v3_p_q |=> v3_p_q)
        else $error("request lost while disabled");

    // level mode keeps no stored request
    level_nostore_a: assert property (
        ce && les_q && !a_low
        |=> !v1_p_q && !(pc_load_q && irq_vec_num_q == NUM_1))
        else $error("vector 1 served or stored in level mode");

    // an active edge is always caught, even during service
    edge_keep_a: assert property (
        ce && b_edge |=> v2_p_q ##1 v2_p_q || $past(take2))
        else $error("vector 2 edge lost");

    // sleep is refused while an enabled request waits
    lp_refuse_a: assert property (
        ce && lp_q == LP_RUN && core_lp_req && pend_en
        |=> lp_refused_q && lp_q == LP_RUN)
        else $error("low power entered with request pending");

    // nothing wakes the part with the global enable clear
    no_wake_a: assert property (
        ce && lp_q != LP_RUN && !gen_q |=> lp_q == $past(lp_q))
        else $error("woke with global enable clear");

    // option write lands in the three kept bits
    opt_write_a: assert property (
        ce && wr_opt |=> {les_q, esb_q, gen_q} == $past(rb.wr_data[6:4]))
        else $error("option write not stored");
endmodule // mic_top

// >>> test/mic_core_model.sv
`timescale 1ns/1ps
// core stand-in: after each vector it stays in the routine five cycles,
// so that a second pending source has to wait its turn
module mic_core_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    input wire logic pc_load,
    input wire logic [mic_pkg::NUM_W-1:0] vec_num,
    output logic core_instr_done,
    output logic core_in_isr,
    output logic core_in_nmi
);
    import mic_pkg::*;
    logic [2:0] cnt_q;
    // the bench holds run low to let requests pile up; no instruction
    // completes in the cycle the pc is reloaded, else a second vector
    // would be taken before the routine is entered
    assign core_instr_done = run && !pc_load;
    // routine entry on a vector load, exit when the count runs out
    always_ff @(posedge clk) begin
        if (srst || (!pc_load && cnt_q == 3'h0)) begin
            cnt_q <= 3'h0;
            core_in_nmi <= 1'b0;
            core_in_isr <= 1'b0;
        end else if (pc_load) begin
            cnt_q <= 3'h4;
            core_in_nmi <= (vec_num == NUM_NMI);
            core_in_isr <= (vec_num != NUM_NMI);
        end else begin
            cnt_q <= cnt_q - 3'h1;
        end
    end
endmodule // mic_core_model

// >>> test/testbench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, e); end end
module testbench;
    import mic_pkg::*;
    logic clk = 1'b0, srst = 1'b1, ce = 1'b1, run = 1'b0, nmi_pin_n = 1'b1;
    logic timer_zero_evt = 1'b0, conv_eoc_evt = 1'b0, core_lp_req = 1'b0;
    logic core_lp_stop = 1'b0, s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0;
    logic s_axil_bready = 1'b0, s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
    logic [3:0] s_axil_wstrb = 4'hF, porta_pins = 4'hF, portb_pins = 4'hF;
    logic [3:0] porta_irq_en = 4'h0, portb_irq_en = 4'h0;
    logic [ADDR_W-1:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
    logic [DATA_W-1:0] s_axil_wdata = 32'h0, s_axil_rdata, rd;
    logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready;
    logic s_axil_rvalid, irq, pc_load, lowpower, lp_stop, lp_refused, wake;
    logic core_instr_done, core_in_isr, core_in_nmi;
    logic [1:0] s_axil_bresp, s_axil_rresp, rr;
    logic [VEC_W-1:0] pc_vector;
    logic [VEC_W-1:0] vq[$];
    logic [NUM_W-1:0] irq_vec_num;
    int errors = 0, tests_run = 0, nref = 0, nwake = 0;
    mic_top i_dut (.clk, .srst, .ce, .s_axil_awvalid, .s_axil_awready,
        .s_axil_awaddr, .s_axil_wvalid, .s_axil_wready, .s_axil_wdata,
        .s_axil_wstrb, .s_axil_bvalid, .s_axil_bready, .s_axil_bresp,
        .s_axil_arvalid, .s_axil_arready, .s_axil_araddr, .s_axil_rvalid,
        .s_axil_rready, .s_axil_rdata, .s_axil_rresp, .irq, .nmi_pin_n,
        .porta_pins, .porta_irq_en, .portb_pins, .portb_irq_en,
        .timer_zero_evt, .conv_eoc_evt, .core_instr_done, .core_in_isr,
        .core_in_nmi, .core_lp_req, .core_lp_stop, .pc_load, .pc_vector,
        .irq_vec_num, .lowpower, .lp_stop, .lp_refused, .wake);
    mic_core_model i_core (.clk, .srst, .run, .pc_load,
        .vec_num(irq_vec_num), .core_instr_done, .core_in_isr, .core_in_nmi);
    // 50 mhz clock
    initial begin
        forever #10 clk = ~clk;
    end
    // log every vector taken and every refused sleep
    always @(posedge clk) begin
        if (pc_load === 1'b1) vq.push_back(pc_vector);
        if (lp_refused === 1'b1) nref++;
        if (wake === 1'b1) nwake++;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // write: each channel dropped on its own ready, then wait for b
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ah, wh;
        @(posedge clk);
        ah = 1'b1;
        wh = 1'b1;
        s_axil_awaddr <= a;
        s_axil_wdata <= d;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        s_axil_bready <= 1'b1;
        while (ah || wh) begin
            @(posedge clk);
            if (s_axil_awready === 1'b1) begin
                ah = 1'b0;
                s_axil_awvalid <= 1'b0;
            end
            if (s_axil_wready === 1'b1) begin
                wh = 1'b0;
                s_axil_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (s_axil_bvalid !== 1'b1);
        rr = s_axil_bresp;
        s_axil_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge clk);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'b1;
        s_axil_rready <= 1'b1;
        do @(posedge clk); while (s_axil_arready !== 1'b1);
        s_axil_arvalid <= 1'b0;
        do @(posedge clk); while (s_axil_rvalid !== 1'b1);
        rd = s_axil_rdata;
        rr = s_axil_rresp;
        s_axil_rready <= 1'b0;
    endtask
    task automatic stop_test;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // a hang ends the run as a failure
    initial begin
        #100us;
        errors++;
        stop_test();
    end
    // main sequence; run low holds requests back from the core
    initial begin
        tk(10);
        srst <= 1'b0;
        porta_irq_en <= 4'h1;
        portb_irq_en <= 4'h1;
        axr(OFF_OPT);
        `CHK({rr, rd}, 34'h0)
        axr(8'h40);
        `CHK(rr, 2'h2)
        axw(8'h44, 32'h1F);
        `CHK(rr, 2'h2)
        axw(OFF_MASK, 32'h1F);
        `CHK(rr, 2'h0)
        timer_zero_evt <= 1'b1;
        conv_eoc_evt <= 1'b1;
        porta_pins <= 4'hE;
        portb_pins <= 4'hE;
        tk(1);
        timer_zero_evt <= 1'b0;
        conv_eoc_evt <= 1'b0;
        run <= 1'b1;
        tk(8);
        axr(OFF_STATUS);
        `CHK({irq, rd[4:0]}, 6'h3E)
        `CHK(vq.size(), 0)
        axw(OFF_OPT, 32'h10);
        tk(40);
        `CHK(vq.size(), 4)
        for (int i = 0; i < 4; i++) `CHK(vq[i], 12'hFF6 - 12'h2 * i)
        axw(OFF_MASK, 32'h0);
        tk(2);
        `CHK(irq, 1'b0)
        axw(OFF_STATUS, 32'h1F);
        axr(OFF_STATUS);
        `CHK(rd[4:0], 5'h00)
        vq.delete();
        axw(OFF_OPT, 32'h50);
        tk(30);
        porta_pins <= 4'hF;
        portb_pins <= 4'hF;
        tk(6);
        `CHK(vq.size() > 2, 1'b1)
        vq.delete();
        axw(OFF_OPT, 32'h30);
        tk(8);
        `CHK(vq.size(), 1)
        portb_pins <= 4'hE;
        tk(8);
        `CHK(vq.size(), 1)
        portb_pins <= 4'hF;
        tk(8);
        `CHK(vq.size(), 2)
        vq.delete();
        portb_irq_en <= 4'h3;
        axw(OFF_OPT, 32'h10);
        portb_pins <= 4'hD;
        tk(8);
        portb_pins <= 4'hC;
        tk(8);
        `CHK(vq.size(), 1)
        portb_pins <= 4'hF;
        run <= 1'b0;
        timer_zero_evt <= 1'b1;
        tk(1);
        timer_zero_evt <= 1'b0;
        tk(2);
        core_lp_req <= 1'b1;
        tk(1);
        core_lp_req <= 1'b0;
        tk(2);
        `CHK({nref[1:0], lowpower}, 3'h2)
        run <= 1'b1;
        axw(OFF_OPT, 32'h0);
        core_lp_stop <= 1'b1;
        core_lp_req <= 1'b1;
        tk(1);
        core_lp_req <= 1'b0;
        vq.delete();
        nmi_pin_n <= 1'b0;
        tk(8);
        `CHK({lp_stop, vq[0]}, 13'h1FFC)
        `CHK(nwake, 0)
        axw(OFF_OPT, 32'h10);
        portb_pins <= 4'hE;
        tk(8);
        `CHK({lowpower, vq[1]}, 13'h0FF4)
        `CHK(nwake, 1)
        // an event while the clock enable is low must be lost
        axw(OFF_STATUS, 32'h1F);
        ce <= 1'b0;
        timer_zero_evt <= 1'b1;
        tk(1);
        ce <= 1'b1;
        timer_zero_evt <= 1'b0;
        axr(OFF_STATUS);
        `CHK(rd[4:0], 5'h00)
        stop_test();
    end
endmodule // testbench
